// ==== core/led_i2c_pkg.sv ====
// Purpose: Shared constants and types for the serial-bus target of the LED driver
// Assumes: One-hot bus states; register pointer is one byte wide
// Notes:   Configuration crosses to the oscillator domain as one packed word
package led_i2c_pkg;

  localparam int NUM_REGS     = 3;
  localparam int NUM_LEDS     = 8;
  localparam int ADDR_W       = 7;

  // Register indices (pointer values)
  localparam int IDX_MODE1     = 0;
  localparam int IDX_MODE2     = 1;
  localparam int IDX_LED_STATE = 2;

  // Field positions
  localparam int MODE1_SLEEP_BIT = 4;
  localparam int MODE2_OUTDRV_BIT = 2;

  // Reset values
  localparam logic [7:0] MODE1_RESET     = 8'h00;
  localparam logic [7:0] MODE2_RESET     = 8'h04;
  localparam logic [7:0] LED_STATE_RESET = 8'h00;
  localparam logic [7:0] LED_ALL_HIGH    = 8'hFF;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef logic [NUM_REGS-1:0][7:0] reg_file_t;

  localparam reg_file_t REGS_RESET = {LED_STATE_RESET, MODE2_RESET, MODE1_RESET};

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_RACK = 6'h10,
    ST_WAIT = 6'h20
  } bus_state_e;

endpackage

// ==== core/bit_sync.sv ====
// Purpose: Two-flop synchroniser for levels entering a clock domain
// Assumes: Each bit is an independent level; multi-bit inputs are quasi-static
// Notes:   The first stage feeds only the second stage
module bit_sync #(
  parameter int            WIDTH    = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // bit_sync

// ==== core/led_driver.sv ====
// Purpose: LED output stage running on the internal oscillator clock
// Assumes: cfg_data is held stable while cfg_req differs from cfg_ack
// Notes:   Outputs freeze while the oscillator is halted by the sleep bit
module led_driver
  import led_i2c_pkg::*;
(
  // Oscillator domain
  input  wire logic                          osc_clock,
  input  wire logic                          rst_n,
  // Configuration handshake from the bus domain
  input  wire led_i2c_pkg::reg_file_t        cfg_data,
  input  wire logic                          cfg_req,
  output logic                               cfg_ack,
  // LED pins
  output logic [led_i2c_pkg::NUM_LEDS-1:0]   led_out,
  output logic [led_i2c_pkg::NUM_LEDS-1:0]   led_oe
);
  import led_i2c_pkg::*;

  typedef struct packed {
    logic                req_p;
    logic                ack;
    reg_file_t           cfg;
    logic [NUM_LEDS-1:0] led_out;
    logic [NUM_LEDS-1:0] led_oe;
  } drv_s;

  drv_s q;
  drv_s d;
  logic req_s;
  logic sleep;

  bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync (
    .clock (osc_clock),
    .rst_n (rst_n),
    .d     (cfg_req),
    .q     (req_s)
  );

  assign sleep = q.cfg[IDX_MODE1][MODE1_SLEEP_BIT];

  always_comb begin
    d       = q;
    d.req_p = req_s;
    // Request edge: data has been stable for the whole sync delay
    if (req_s != q.req_p) begin
      d.cfg = cfg_data;
      d.ack = req_s;
    end
    if (!sleep) begin
      d.led_out = ~q.cfg[IDX_LED_STATE];
      if (q.cfg[IDX_MODE2][MODE2_OUTDRV_BIT]) begin
        d.led_oe = LED_ALL_HIGH;
      end else begin
        // Open drain: drive only the low level
        d.led_oe = q.cfg[IDX_LED_STATE];
      end
    end
  end

  always_ff @(posedge osc_clock or negedge rst_n) begin
    if (!rst_n) begin
      q.req_p   <= 1'b0;
      q.ack     <= 1'b0;
      q.cfg     <= REGS_RESET;
      q.led_out <= LED_ALL_HIGH;
      q.led_oe  <= LED_ALL_HIGH;
    end else begin
      q <= d;
    end
  end

  assign cfg_ack = q.ack;
  assign led_out = q.led_out;
  assign led_oe  = q.led_oe;

  AST_SLEEP_FREEZE: assert property (@(posedge osc_clock) disable iff (!rst_n)
    sleep |=> $stable(led_out) && $stable(led_oe))
    else $error("LED outputs changed while oscillator halted");

endmodule // led_driver

// ==== core/i2c_led_target.sv ====
// Purpose: Target-side serial bus bit and byte engine with a small register file
// Assumes: SCL and SDA are pins, sampled through two flops on clock
// Notes:   Register contents cross to the oscillator clock by a toggle handshake
//
// Summary of operation
// - One bit per SCL pulse; SDA stays stable while SCL is high.
// - Idle bus has both lines high; nobody pulls them low.
// - SDA falling while SCL high is START; begin a new byte sequence.
// - SDA rising while SCL high is STOP; end transfer, go idle.
// - Unlimited bytes per transfer; each eight-bit byte has one acknowledge slot.
// - Transmitter releases SDA during the acknowledge slot; controller clocks it.
// - Addressed receiving device acknowledges every received byte.
// - Acknowledger holds SDA low through the acknowledge clock high phase.
// - After a not-acknowledge the device releases SDA until the next START or STOP.
// - Sleep bit four of mode register one halts the oscillator and LEDs.
// - After reset LED outputs are push-pull and driven high.
module i2c_led_target
  import led_i2c_pkg::*;
(
  // Bus-side clock and reset
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  // Internal oscillator clock
  input  wire logic                                osc_clock,
  // Serial bus pins
  input  wire logic                                scl_in,
  input  wire logic                                sda_in,
  output logic                                     sda_out,
  output logic                                     sda_oe,
  // Address straps
  input  wire logic [led_i2c_pkg::ADDR_W-1:0]      target_addr,
  // LED pins
  output logic      [led_i2c_pkg::NUM_LEDS-1:0]    led_out,
  output logic      [led_i2c_pkg::NUM_LEDS-1:0]    led_oe
);
  import led_i2c_pkg::*;

  typedef struct packed {
    bus_state_e  st;
    logic        scl_p;
    logic        sda_p;
    logic [7:0]  sh;
    logic [3:0]  cnt;
    logic        first;
    logic        rw;
    logic        mack;
    logic        ptr_ok;
    logic [7:0]  ptr;
    reg_file_t   regs;
    reg_file_t   shadow;
    logic        pend;
    logic        req;
    logic        sda_oe;
  } ctl_s;

  ctl_s              q;
  ctl_s              d;
  logic              scl_s;
  logic              sda_s;
  logic [ADDR_W-1:0] addr_s;
  logic              ack_s;
  logic              cfg_ack;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              busy;
  logic [7:0]        rd_byte;

  // Pointer past the register file reads zero and ignores writes
  function automatic logic is_mapped(input logic [7:0] p);
    return p < 8'(NUM_REGS);
  endfunction

  function automatic logic [7:0] read_byte(input reg_file_t r, input logic [7:0] p);
    return is_mapped(p) ? r[p[1:0]] : 8'h00;
  endfunction

  bit_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_bus_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({scl_in, sda_in}),
    .q     ({scl_s, sda_s})
  );

  bit_sync #(.WIDTH(ADDR_W), .RST_VAL('0)) u_addr_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (target_addr),
    .q     (addr_s)
  );

  bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (cfg_ack),
    .q     (ack_s)
  );

  led_driver u_led (
    .osc_clock (osc_clock),
    .rst_n     (rst_n),
    .cfg_data  (q.shadow),
    .cfg_req   (q.req),
    .cfg_ack   (cfg_ack),
    .led_out   (led_out),
    .led_oe    (led_oe)
  );

  assign scl_rise = scl_s & ~q.scl_p;
  assign scl_fall = ~scl_s & q.scl_p;
  assign start_c  = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop_c   = scl_s & q.scl_p & ~q.sda_p & sda_s;
  assign busy     = q.req ^ ack_s;
  assign rd_byte  = read_byte(q.regs, q.ptr);

  always_comb begin
    d       = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    // Shadow is frozen until the oscillator side has taken the last copy
    if (!busy && q.pend) begin
      d.shadow = q.regs;
      d.req    = ~q.req;
      d.pend   = 1'b0;
    end
    if (stop_c) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (start_c) begin
      d.st     = ST_RX;
      d.cnt    = 4'h0;
      d.first  = 1'b1;
      d.rw     = 1'b0;
      d.mack   = 1'b0;
      d.ptr_ok = 1'b0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
            if (q.first) begin
              if (q.sh[7:1] == addr_s) begin
                d.rw     = q.sh[0];
                d.sda_oe = 1'b1;
                d.st     = ST_ACK;
              end else begin
                d.st = ST_WAIT;
              end
            end else begin
              d.sda_oe = 1'b1;
              d.st     = ST_ACK;
              if (!q.ptr_ok) begin
                d.ptr    = q.sh;
                d.ptr_ok = 1'b1;
              end else begin
                if (is_mapped(q.ptr)) begin
                  d.regs[q.ptr[1:0]] = q.sh;
                  d.pend             = 1'b1;
                end
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        ST_ACK: begin
          // Hold low until SCL falls so the level spans the whole high phase
          if (scl_fall) begin
            d.first = 1'b0;
            if (q.rw) begin
              d.sda_oe = ~rd_byte[7];
              d.sh     = {rd_byte[6:0], 1'b0};
              d.cnt    = 4'h1;
              d.ptr    = q.ptr + 8'h01;
              d.st     = ST_TX;
            end else begin
              d.sda_oe = 1'b0;
              d.cnt    = 4'h0;
              d.st     = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (q.cnt == BITS_PER_BYTE) begin
              d.sda_oe = 1'b0;
              d.mack   = 1'b0;
              d.st     = ST_RACK;
            end else begin
              d.sda_oe = ~q.sh[7];
              d.sh     = {q.sh[6:0], 1'b0};
              d.cnt    = q.cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              d.st = ST_WAIT;
            end else begin
              d.mack = 1'b1;
            end
          end else if (scl_fall && q.mack) begin
            d.mack   = 1'b0;
            d.sda_oe = ~rd_byte[7];
            d.sh     = {rd_byte[6:0], 1'b0};
            d.cnt    = 4'h1;
            d.ptr    = q.ptr + 8'h01;
            d.st     = ST_TX;
          end
        end
        ST_WAIT: begin
          d.sda_oe = 1'b0;
        end
        default: begin
          d.st     = ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q.st     <= ST_IDLE;
      q.scl_p  <= 1'b1;
      q.sda_p  <= 1'b1;
      q.sh     <= 8'h00;
      q.cnt    <= 4'h0;
      q.first  <= 1'b0;
      q.rw     <= 1'b0;
      q.mack   <= 1'b0;
      q.ptr_ok <= 1'b0;
      q.ptr    <= 8'h00;
      q.regs   <= REGS_RESET;
      q.shadow <= REGS_RESET;
      q.pend   <= 1'b0;
      q.req    <= 1'b0;
      q.sda_oe <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Open-drain data line: only the low level is ever driven
  assign sda_out = 1'b0;
  assign sda_oe  = q.sda_oe;

  AST_START_RX: assert property (@(posedge clock) disable iff (!rst_n)
    start_c && !stop_c |=> q.st == ST_RX && q.cnt == 4'h0 && !q.sda_oe)
    else $error("START did not open a new byte");

  AST_STOP_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    stop_c |=> q.st == ST_IDLE && !q.sda_oe)
    else $error("STOP did not return to idle");

  AST_IDLE_RELEASED: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_IDLE |-> !q.sda_oe)
    else $error("SDA driven while idle");

  AST_BIT_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RX && scl_rise && !start_c && !stop_c |=> q.cnt == $past(q.cnt) + 4'h1)
    else $error("Bit count not advanced on SCL rise");

  AST_WRITE_ACK: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RX && !q.first && scl_fall && q.cnt == BITS_PER_BYTE && !start_c && !stop_c
    |=> q.st == ST_ACK && q.sda_oe)
    else $error("Received byte not acknowledged");

  AST_ACK_HELD: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_ACK && scl_rise && !stop_c |=> q.sda_oe throughout (!scl_fall [*2]))
    else $error("Acknowledge released during SCL high");

  AST_SDA_CHANGE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(q.sda_oe) && !$past(stop_c) && !$past(start_c) |-> !q.scl_p)
    else $error("SDA drive changed while SCL high");

  AST_RACK_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RACK |-> !q.sda_oe)
    else $error("SDA driven in controller acknowledge slot");

  AST_NACK_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RACK && scl_rise && sda_s && !start_c && !stop_c
    |=> q.st == ST_WAIT ##1 !q.sda_oe [*3])
    else $error("SDA not released after not-acknowledge");

  AST_CFG_SENT: assert property (@(posedge clock) disable iff (!rst_n)
    q.pend && !busy |=> busy && q.shadow == $past(q.regs))
    else $error("Configuration not handed to oscillator domain");

  AST_FOREIGN_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RX && q.first && scl_fall && q.cnt == BITS_PER_BYTE && q.sh[7:1] != addr_s
    && !start_c && !stop_c |=> q.st == ST_WAIT && !q.sda_oe)
    else $error("Foreign address acknowledged");

  AST_ACK_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_ACK && scl_fall && !q.rw && !start_c && !stop_c
    |=> q.st == ST_RX && !q.sda_oe && q.cnt == 4'h0)
    else $error("Acknowledge not released after its clock pulse");

  AST_TX_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_ACK && scl_fall && q.rw && !start_c && !stop_c
    |=> q.st == ST_TX && q.sda_oe == !$past(rd_byte[7]))
    else $error("First read bit not driven after address acknowledge");

  AST_TX_STABLE_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_TX && scl_s && q.scl_p && !start_c && !stop_c |=> $stable(q.sda_oe))
    else $error("Transmitted bit changed while SCL high");

  AST_WAIT_RELEASED: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_WAIT |-> !q.sda_oe)
    else $error("SDA driven while waiting for START or STOP");

  AST_READ_NEXT: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RACK && q.mack && scl_fall && !start_c && !stop_c |=> q.st == ST_TX && q.cnt == 4'h1)
    else $error("Acknowledged read did not start the next byte");

  // Unmapped pointers must never alias onto a real register through the short index
  AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RX && !q.first && q.ptr_ok && !is_mapped(q.ptr) && scl_fall && q.cnt == BITS_PER_BYTE
    && !start_c && !stop_c |=> q.regs == $past(q.regs))
    else $error("Write to unmapped pointer changed the register file");

  COV_ADDR_ACK: cover property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RX && q.first ##1 q.st == ST_ACK);
  COV_REG_WRITE: cover property (@(posedge clock) disable iff (!rst_n)
    q.pend ##[1:200] !busy && !q.pend);
  COV_READ_NACK: cover property (@(posedge clock) disable iff (!rst_n)
    q.st == ST_RACK ##1 q.st == ST_WAIT);
  COV_STOP: cover property (@(posedge clock) disable iff (!rst_n)
    stop_c && q.st != ST_IDLE);

endmodule // i2c_led_target

// ==== sim/i2c_ctl_model.sv ====
// Purpose: Behavioural bus controller that clocks SCL and drives SDA as the far party
// Assumes: Lines are open drain with pull-ups; SCL phases of 8 clocks meet the target's sampling
// Notes:   SCL stands still between frames; read bits return x when SDA moved during SCL high
module i2c_ctl_model (
  // Clock
  input  wire logic clock,
  // Wired bus level
  input  wire logic sda_line,
  // Pull-down enables
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines released while idle
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Only called with the bus idle or with SCL low inside a frame
  task automatic start();
    sda_low <= 1'b0;
    hold(4);
    scl_low <= 1'b0;
    hold(8);
    sda_low <= 1'b1;
    hold(8);
    scl_low <= 1'b1;
    hold(4);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    hold(4);
    scl_low <= 1'b0;
    hold(8);
    sda_low <= 1'b0;
    hold(8);
  endtask

  // SDA set only while SCL low; the sample must agree at both ends of the high phase
  task automatic xfer_bit(input logic b, output logic r);
    logic r1;
    sda_low <= ~b;
    hold(4);
    scl_low <= 1'b0;
    hold(2);
    r1 = sda_line;
    hold(6);
    r = (r1 === sda_line) ? r1 : 1'bx;
    scl_low <= 1'b1;
    hold(4);
  endtask

  // Ninth pulse with SDA released; returns the bit seen, 0 meaning acknowledged
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(v[i], r);
    end
    xfer_bit(1'b1, ack);
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, v[i]);
    end
    xfer_bit(last, r);
  endtask
endmodule // i2c_ctl_model

// ==== sim/i2c_slave_bit_byte_interface_bench.sv ====
// Purpose: Self-checking bench for the serial-bus target and its LED stage
// Assumes: Register map 0 mode1, 1 mode2, 2 led state; LED pin low means on
// Notes:   Crossing waits of 40 clocks cover the handshake to the oscillator domain
module i2c_slave_bit_byte_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import led_i2c_pkg::*;

  localparam logic [6:0] DEV_ADDR = 7'h2a;
  localparam int         LIMIT    = 30000;

  logic       clock;
  logic       osc_clock;
  logic       rst_n;
  logic       scl_low;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe;
  logic       sda_line;
  logic [6:0] target_addr;
  logic [7:0] led_out;
  logic [7:0] led_oe;
  int         fail_count;
  int         cmp_count;
  int         cycles = 0;

  // Open-drain wire with pull-up
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  i2c_ctl_model ctl (
    .clock    (clock),
    .sda_line (sda_line),
    .scl_low  (scl_low),
    .sda_low  (sda_low)
  );

  i2c_led_target uut (
    .clock       (clock),
    .rst_n       (rst_n),
    .osc_clock   (osc_clock),
    .scl_in      (~scl_low),
    .sda_in      (sda_line),
    .sda_out     (sda_out),
    .sda_oe      (sda_oe),
    .target_addr (target_addr),
    .led_out     (led_out),
    .led_oe      (led_oe)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Odd offset keeps the two clocks out of phase
  initial begin
    osc_clock = 1'b0;
    #7;
    forever #32 osc_clock = ~osc_clock;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] val);
    logic a;
    ctl.start();
    ctl.wr_byte({DEV_ADDR, 1'b0}, a);
    check("addr ack", 8'h00, {7'h00, a});
    ctl.wr_byte(ptr, a);
    check("ptr ack", 8'h00, {7'h00, a});
    ctl.wr_byte(val, a);
    check("data ack", 8'h00, {7'h00, a});
    ctl.stop();
    ctl.hold(40);
  endtask

  task automatic t_reset();
    check("led_out", 8'hff, led_out);
    check("led_oe", 8'hff, led_oe);
    check("idle sda", 8'h01, {7'h00, sda_line});
    check("sda_out", 8'h00, {7'h00, sda_out});
    $display("test reset done");
  endtask

  task automatic t_burst();
    logic a;
    ctl.start();
    ctl.wr_byte({DEV_ADDR, 1'b0}, a);
    check("addr ack", 8'h00, {7'h00, a});
    ctl.wr_byte(8'h01, a);
    ctl.wr_byte(8'h00, a);
    check("mode2 ack", 8'h00, {7'h00, a});
    ctl.wr_byte(8'h5a, a);
    check("state ack", 8'h00, {7'h00, a});
    ctl.stop();
    ctl.hold(40);
    check("led_out", 8'ha5, led_out);
    check("led_oe", 8'h5a, led_oe);
    $display("test burst done");
  endtask

  task automatic t_read();
    logic       a;
    logic       seen;
    logic [7:0] v;
    ctl.start();
    ctl.wr_byte({DEV_ADDR, 1'b0}, a);
    ctl.wr_byte(8'h00, a);
    ctl.start();
    ctl.wr_byte({DEV_ADDR, 1'b1}, a);
    check("read addr ack", 8'h00, {7'h00, a});
    ctl.rd_byte(1'b0, v);
    check("mode1", 8'h00, v);
    ctl.rd_byte(1'b0, v);
    check("mode2", 8'h00, v);
    ctl.rd_byte(1'b1, v);
    check("led state", 8'h5a, v);
    seen = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clock);
      seen = seen | sda_oe;
    end
    check("released", 8'h00, {7'h00, seen});
    ctl.stop();
    ctl.hold(8);
    $display("test read done");
  endtask

  task automatic t_sleep();
    write_reg(8'h00, 8'h10);
    write_reg(8'h02, 8'hc3);
    check("frozen", 8'ha5, led_out);
    write_reg(8'h00, 8'h00);
    check("running", 8'h3c, led_out);
    $display("test sleep done");
  endtask

  task automatic t_abort();
    logic r;
    ctl.start();
    for (int i = 0; i < 4; i++) begin
      ctl.xfer_bit(DEV_ADDR[6 - i], r);
    end
    ctl.stop();
    check("abort sda_oe", 8'h00, {7'h00, sda_oe});
    write_reg(8'h02, 8'h0f);
    check("after abort", 8'hf0, led_out);
    $display("test abort done");
  endtask

  task automatic t_foreign();
    logic a;
    ctl.start();
    ctl.wr_byte({DEV_ADDR ^ 7'h01, 1'b0}, a);
    check("no ack", 8'h01, {7'h00, a});
    ctl.wr_byte(8'h02, a);
    ctl.wr_byte(8'hff, a);
    ctl.stop();
    ctl.hold(40);
    check("untouched", 8'hf0, led_out);
    $display("test foreign done");
  endtask

  // Pointer 06 shares its low bits with the LED state register, so aliasing would show
  task automatic t_unmapped();
    logic       a;
    logic [7:0] v;
    ctl.start();
    ctl.wr_byte({DEV_ADDR, 1'b0}, a);
    ctl.wr_byte(8'h06, a);
    ctl.wr_byte(8'h55, a);
    check("unmapped ack", 8'h00, {7'h00, a});
    ctl.start();
    ctl.wr_byte({DEV_ADDR, 1'b0}, a);
    ctl.wr_byte(8'h06, a);
    ctl.start();
    ctl.wr_byte({DEV_ADDR, 1'b1}, a);
    check("unmapped addr ack", 8'h00, {7'h00, a});
    ctl.rd_byte(1'b1, v);
    check("unmapped read", 8'h00, v);
    ctl.stop();
    ctl.hold(40);
    check("unmapped led_out", 8'hf0, led_out);
    check("unmapped led_oe", 8'h0f, led_oe);
    $display("test unmapped done");
  endtask

  initial begin
    rst_n       = 1'b0;
    target_addr = DEV_ADDR;
    fail_count  = 0;
    cmp_count   = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_burst();
    t_read();
    t_sleep();
    t_abort();
    t_foreign();
    t_unmapped();
    conclude();
  end
endmodule // i2c_slave_bit_byte_interface_bench
